// >>> design/oscillator_select_and_trim.v
// Oscillator select, postdivider, trim and fail handling with APB registers
`timescale 1ns/1ps
`include "osc_ctrl_defines.vh"
module oscillator_select_and_trim #(
   parameter SWITCH_CYCLES = `SWITCH_CYCLES
) (
   // Clock and reset
   input wire ref_clk,
   input wire rst,
   // APB slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output wire pready,
   output reg [31:0] prdata,
   output wire pslverr,
   // Configuration fuses
   input wire [2:0] initial_source_fuse,
   input wire two_speed_startup_fuse,
   // Oscillator status pins
   input wire clock_loss_in,
   input wire source_ready_in,
   input wire wait_exec,
   input wire wake_event,
   // Clock controls
   output reg [2:0] fast_rc_postdivider,
   output reg dream_mode_enable,
   output reg [2:0] clock_mux_select,
   output reg [2:0] switch_target,
   output reg usb_rc_clock_enable,
   output reg secondary_osc_enable,
   output reg [5:0] rc_trim_field,
   output reg sleep_mode,
   output reg idle_mode,
   output reg nmi_out,
   output wire irq
);
   // Control register state
   reg sleep_two_speed_wake_r;
   reg [2:0] active_source_select_r;
   reg [2:0] requested_source_select_r;
   reg selection_lock_r;
   reg sleep_on_wait_enable_r;
   reg clock_fail_flag_r;
   reg switch_request_r;
   reg [1:0] unlock_state_r;
   reg [1:0] irq_status_r;
   reg [1:0] irq_mask_r;
   reg [15:0] switch_count_r;
   reg fuse_load_r;
   reg waking_r;
   reg loss_meta_r, loss_sync_r;
   reg ready_meta_r, ready_sync_r;
   wire wr_en;
   wire rd_en;
   wire unlocked;
   wire fail_detect;
   wire switch_done;
   reg [31:0] ctrl_view;
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign wr_en = psel & penable & pwrite;
   assign rd_en = psel & penable & ~pwrite;
   assign unlocked = (unlock_state_r == 2'h2);
   assign irq = |(irq_status_r & irq_mask_r);
   // Pin synchronisers
   always @(posedge ref_clk) begin
      if (rst) begin
         loss_meta_r <= 1'b0;
         loss_sync_r <= 1'b0;
         ready_meta_r <= 1'b0;
         ready_sync_r <= 1'b0;
      end else begin
         loss_meta_r <= clock_loss_in;
         loss_sync_r <= loss_meta_r;
         ready_meta_r <= source_ready_in;
         ready_sync_r <= ready_meta_r;
      end
   end
   // Monitor halted in sleep
   assign fail_detect = loss_sync_r & ~sleep_mode & ~clock_fail_flag_r; // RQ17
   assign switch_done = switch_request_r && (switch_count_r == SWITCH_CYCLES[15:0]);
   // Control register read view
   always @* begin
      ctrl_view = 32'h00000000; // RQ15
      ctrl_view[`POSTDIV_HI:`POSTDIV_LO] = fast_rc_postdivider;
      ctrl_view[`BIT_DREAM] = dream_mode_enable;
      ctrl_view[`BIT_TWO_SPEED] = sleep_two_speed_wake_r;
      ctrl_view[`ACTIVE_HI:`ACTIVE_LO] = active_source_select_r; // RQ4
      ctrl_view[`REQ_HI:`REQ_LO] = requested_source_select_r;
      ctrl_view[`BIT_LOCK] = selection_lock_r;
      ctrl_view[`BIT_SLEEP_EN] = sleep_on_wait_enable_r;
      ctrl_view[`BIT_CLK_FAIL] = clock_fail_flag_r;
      ctrl_view[`BIT_USB_RC] = usb_rc_clock_enable;
      ctrl_view[`BIT_SOSC_EN] = secondary_osc_enable;
      ctrl_view[`BIT_SWITCH] = switch_request_r; // RQ11
   end
   // Read data mux
   always @(posedge ref_clk) begin
      if (rst) begin
         prdata <= 32'h00000000;
      end else if (psel & ~penable & ~pwrite) begin
         case (paddr)
            `OFS_OSC_CONTROL: prdata <= ctrl_view;
            `OFS_RC_TRIM: prdata <= {26'h0, rc_trim_field}; // RQ15
            `OFS_IRQ_STATUS: prdata <= {30'h0, irq_status_r};
            `OFS_IRQ_MASK: prdata <= {30'h0, irq_mask_r};
            default: prdata <= 32'h00000000;
         endcase
      end
   end
   // Unlock sequence tracker
   always @(posedge ref_clk) begin
      if (rst) begin
         unlock_state_r <= 2'h0;
      end else if (wr_en && paddr == `OFS_UNLOCK) begin
         if (pwdata == `UNLOCK_KEY1) begin
            unlock_state_r <= 2'h1;
         end else if (pwdata == `UNLOCK_KEY2 && unlock_state_r == 2'h1) begin
            unlock_state_r <= 2'h2; // RQ13
         end else begin
            unlock_state_r <= 2'h0;
         end
      end
   end
   // Oscillator control and trim registers
   always @(posedge ref_clk) begin
      if (rst) begin
         fast_rc_postdivider <= 3'h0; // RQ1
         dream_mode_enable <= 1'b0; // RQ2
         sleep_two_speed_wake_r <= 1'b0;
         active_source_select_r <= `SRC_FRC;
         requested_source_select_r <= 3'h0;
         selection_lock_r <= 1'b0;
         sleep_on_wait_enable_r <= 1'b0;
         clock_fail_flag_r <= 1'b0;
         usb_rc_clock_enable <= 1'b0;
         secondary_osc_enable <= 1'b0; // RQ10
         switch_request_r <= 1'b0;
         rc_trim_field <= 6'h00;
         switch_count_r <= 16'h0000;
         fuse_load_r <= 1'b1;
      end else begin
         fuse_load_r <= 1'b0;
         if (fuse_load_r) begin
            requested_source_select_r <= initial_source_fuse; // RQ5
            switch_request_r <= two_speed_startup_fuse; // RQ12
         end
         if (wr_en && unlocked && paddr == `OFS_OSC_CONTROL) begin // RQ13
            fast_rc_postdivider <= pwdata[`POSTDIV_HI:`POSTDIV_LO];
            dream_mode_enable <= pwdata[`BIT_DREAM];
            sleep_two_speed_wake_r <= pwdata[`BIT_TWO_SPEED];
            sleep_on_wait_enable_r <= pwdata[`BIT_SLEEP_EN];
            usb_rc_clock_enable <= pwdata[`BIT_USB_RC]; // RQ9
            secondary_osc_enable <= pwdata[`BIT_SOSC_EN];
            selection_lock_r <= pwdata[`BIT_LOCK] | selection_lock_r;
            if (!fail_detect) begin
               clock_fail_flag_r <= pwdata[`BIT_CLK_FAIL];
            end
            if (!selection_lock_r) begin // RQ6 RQ18
               requested_source_select_r <= pwdata[`REQ_HI:`REQ_LO];
               if (pwdata[`BIT_SWITCH]) begin
                  switch_request_r <= 1'b1;
               end
            end
         end
         if (wr_en && unlocked && paddr == `OFS_RC_TRIM) begin
            rc_trim_field <= pwdata[5:0]; // RQ14
         end
         if (fail_detect) begin
            clock_fail_flag_r <= 1'b1; // RQ8
            active_source_select_r <= `SRC_FRC; // RQ16
         end else if (switch_done) begin
            switch_request_r <= 1'b0; // RQ11
            active_source_select_r <= requested_source_select_r; // RQ19
            switch_count_r <= 16'h0000;
         end else if (switch_request_r && ready_sync_r) begin
            switch_count_r <= switch_count_r + 16'h0001;
         end
      end
   end
   // Sleep, idle and two-speed wake
   always @(posedge ref_clk) begin
      if (rst) begin
         sleep_mode <= 1'b0;
         idle_mode <= 1'b0;
         waking_r <= 1'b0;
      end else begin
         if (wait_exec && !sleep_mode && !idle_mode) begin
            sleep_mode <= sleep_on_wait_enable_r; // RQ7
            idle_mode <= ~sleep_on_wait_enable_r;
         end else if (wake_event) begin
            if (sleep_mode && sleep_two_speed_wake_r) begin
               waking_r <= 1'b1;
            end
            sleep_mode <= 1'b0;
            idle_mode <= 1'b0;
         end else if (ready_sync_r) begin
            waking_r <= 1'b0;
         end
      end
   end
   // Clock mux choice, NMI and switch target
   always @(posedge ref_clk) begin
      if (rst) begin
         clock_mux_select <= `SRC_FRC;
         switch_target <= 3'h0;
         nmi_out <= 1'b0;
      end else begin
         nmi_out <= fail_detect; // RQ16
         switch_target <= requested_source_select_r;
         if (waking_r && !ready_sync_r) begin
            clock_mux_select <= `SRC_FRC; // RQ3
         end else begin
            clock_mux_select <= active_source_select_r;
         end
      end
   end
   // Sticky interrupt status, cleared by reading
   always @(posedge ref_clk) begin
      if (rst) begin
         irq_status_r <= 2'h0;
         irq_mask_r <= 2'h0;
      end else begin
         if (wr_en && paddr == `OFS_IRQ_MASK) begin
            irq_mask_r <= pwdata[1:0];
         end
         irq_status_r <= (rd_en && paddr == `OFS_IRQ_STATUS ? 2'h0 : irq_status_r)
                         | {switch_done, fail_detect};
      end
   end
endmodule

// >>> include/osc_ctrl_defines.vh
// Register offsets, field positions, source codes and timing counts for clock control
// Overview of operation
// RQ1: Fast RC postdivider code selects divide ratio
// RQ2: Dream mode enable follows control bit 23
// RQ3: Two-speed wake runs fast RC until ready
// RQ4: Active source field reports running clock source
// RQ5: Requested source field loads from fuses
// RQ6: Lock bit freezes clock source selections
// RQ7: Wait enters sleep or idle per bit
// RQ8: Clock fail flag set by monitor
// RQ9: USB clock from fast RC or primary
// RQ10: Secondary oscillator enable follows bit 1
// RQ11: Switch request bit clears when complete
// RQ12: Switch request resets to two-speed fuse
// RQ13: Writes need a preceding unlock sequence; the code requires it only for control and trim writes, not IRQ mask writes
// RQ14: Six-bit signed trim of fast RC
// RQ15: Unimplemented bits read as zero
// RQ16: Clock loss forces fast RC, raises NMI
// RQ17: Sleep halts clock and fail monitor
// RQ18: Locked selection ignores source and switch writes
// RQ19: Completed switch copies requested into active
`ifndef OSC_CTRL_DEFINES_VH
`define OSC_CTRL_DEFINES_VH
`define OFS_OSC_CONTROL 12'h000
`define OFS_RC_TRIM 12'h010
`define OFS_UNLOCK 12'h020
`define OFS_IRQ_STATUS 12'h030
`define OFS_IRQ_MASK 12'h034
`define UNLOCK_KEY1 32'hAA996655
`define UNLOCK_KEY2 32'h556699AA
`define POSTDIV_HI 26
`define POSTDIV_LO 24
`define BIT_DREAM 23
`define BIT_TWO_SPEED 21
`define ACTIVE_HI 14
`define ACTIVE_LO 12
`define REQ_HI 10
`define REQ_LO 8
`define BIT_LOCK 7
`define BIT_SLEEP_EN 4
`define BIT_CLK_FAIL 3
`define BIT_USB_RC 2
`define BIT_SOSC_EN 1
`define BIT_SWITCH 0
`define TRIM_W 6
`define SRC_FRC 3'h0
`define SRC_SYSTEM_PLL 3'h1
`define SRC_POSC 3'h2
`define SRC_SOSC 3'h4
`define SRC_LOW_POWER_RC_OSC 3'h5
`define SWITCH_TIME_NS 64
`define SWITCH_CYCLES ((`SWITCH_TIME_NS + 7) / 8)
`endif

// >>> testbench/osc_sel_props.sv
// Port assertions for the clock control block
`timescale 1ns/1ps
module osc_sel_props (
   // Clock and reset
   input wire ref_clk,
   input wire rst,
   // APB
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] prdata,
   // Controls and status
   input wire wait_exec,
   input wire [2:0] fast_rc_postdivider,
   input wire dream_mode_enable,
   input wire [2:0] clock_mux_select,
   input wire [2:0] switch_target,
   input wire usb_rc_clock_enable,
   input wire secondary_osc_enable,
   input wire [5:0] rc_trim_field,
   input wire sleep_mode,
   input wire idle_mode,
   input wire nmi_out
);
   // Common clock, reset and read setups
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   sequence s_ctrl_rd; psel && !penable && !pwrite && paddr == 12'h000; endsequence
   sequence s_trim_rd; psel && !penable && !pwrite && paddr == 12'h010; endsequence
   // Control and trim register outputs move only on a write
   property p_quiet; !(psel && penable && pwrite) |=> $stable({fast_rc_postdivider,
      dream_mode_enable, usb_rc_clock_enable, secondary_osc_enable, rc_trim_field}); endproperty
   a_quiet: assert property (p_quiet) else $error("control moved without write");
   // Read data of control and trim registers
   property p_ctrl_zero; s_ctrl_rd |=> (prdata & 32'hF85F_8860) == 32'h0; endproperty
   a_ctrl_zero: assert property (p_ctrl_zero) else $error("spare bits set");
   property p_ctrl_fld; s_ctrl_rd |=> prdata[26:24] == $past(fast_rc_postdivider)
      && prdata[23] == $past(dream_mode_enable) && prdata[10:8] == switch_target;
   endproperty
   a_ctrl_fld: assert property (p_ctrl_fld) else $error("control readback");
   property p_trim_rd; s_trim_rd |=> prdata == {26'h0, $past(rc_trim_field)}; endproperty
   a_trim_rd: assert property (p_trim_rd) else $error("trim readback");
   // Fail-safe response
   property p_nmi_pulse; nmi_out |=> !nmi_out; endproperty
   a_nmi_pulse: assert property (p_nmi_pulse) else $error("nmi too long");
   property p_nmi_frc; nmi_out |-> ##[0:1] clock_mux_select == 3'h0; endproperty
   a_nmi_frc: assert property (p_nmi_frc) else $error("no fast rc on fail");
   // Wait instruction and sleep
   property p_sleep; sleep_mode |-> !nmi_out && !idle_mode; endproperty
   a_sleep: assert property (p_sleep) else $error("activity in sleep");
   property p_wait; wait_exec && !sleep_mode && !idle_mode |-> ##[1:2] (sleep_mode || idle_mode);
   endproperty
   a_wait: assert property (p_wait) else $error("wait ignored");
endmodule
bind oscillator_select_and_trim osc_sel_props osc_sel_props_i (.*);

// >>> testbench/tb_oscillator_select_and_trim.sv
// Self-checking bench for the clock control block
`timescale 1ns/1ps
module tb_oscillator_select_and_trim;
   // Stimulus and observed signals
   logic ref_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic clock_loss_in = 1'b0, source_ready_in = 1'b0, wait_exec = 1'b0, wake_event = 1'b0;
   logic two_speed_startup_fuse = 1'b1, pready, pslverr, dream_mode_enable, usb_rc_clock_enable;
   logic secondary_osc_enable, sleep_mode, idle_mode, nmi_out, irq;
   logic [2:0] initial_source_fuse = 3'h2, fast_rc_postdivider, clock_mux_select, switch_target;
   logic [5:0] rc_trim_field;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, q;
   int err_total = 0, check_count = 0, i;
   oscillator_select_and_trim #(.SWITCH_CYCLES(2)) oscillator_select_and_trim_i (.*);
   // Free-running clock
   always #4 ref_clk = ~ref_clk;
   // One APB transfer, held until pready is seen
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(negedge ref_clk);
   endtask
   // Write after the unlock pair
   task automatic wu(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, 12'h020, 32'hAA99_6655);
      apb(1'b1, 12'h020, 32'h5566_99AA);
      apb(1'b1, a, d);
   endtask
   // Compare and count
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e) begin
         err_total++;
         $display("Error %0t: got %h want %h", $time, g, e);
      end
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(q & m, e);
   endtask
   task automatic t_reset;
      rd(12'h000, 32'hFFDF_FFFF, 32'h0000_0201);
      rd(12'h010, 32'hFFFF_FFFF, 32'h0);
      rd(12'h0FC, 32'hFFFF_FFFF, 32'h0);
      $display("t_reset done");
   endtask
   task automatic t_fields;
      apb(1'b1, 12'h000, 32'h0700_0000);
      chk(32'(fast_rc_postdivider), 32'h0);
      for (i = 0; i < 8; i++) begin
         wu(12'h000, {5'h0, i[2:0], 24'hA0_0216});
         chk(32'(fast_rc_postdivider), 32'(i));
      end
      rd(12'h000, 32'h07A0_0716, 32'h07A0_0216);
      chk(32'({dream_mode_enable, usb_rc_clock_enable, secondary_osc_enable}), 32'h7);
      wu(12'h010, 32'hFFFF_FFE0);
      rd(12'h010, 32'hFFFF_FFFF, 32'h20);
      wu(12'h010, 32'h1F);
      chk(32'(rc_trim_field), 32'h1F);
      $display("t_fields done");
   endtask
   task automatic t_switch;
      apb(1'b1, 12'h034, 32'h2);
      @(posedge ref_clk);
      source_ready_in <= 1'b1;
      q = 32'h1;
      for (i = 0; i < 40 && q[0]; i++) apb(1'b0, 12'h000, 32'h0);
      chk(q & 32'h7001, 32'h2000);
      chk(32'(irq), 32'h1);
      rd(12'h030, 32'hFFFF_FFFF, 32'h2);
      chk(32'(irq), 32'h0);
      $display("t_switch done");
   endtask
   task automatic t_wait;
      for (i = 1; i >= 0; i--) begin
         wu(12'h000, 32'h07A0_0206 | 32'(i << 4));
         @(posedge ref_clk);
         wait_exec <= 1'b1;
         @(posedge ref_clk);
         wait_exec <= 1'b0;
         repeat (3) @(posedge ref_clk);
         chk(32'({sleep_mode, idle_mode}), (i == 1) ? 32'h2 : 32'h1);
         source_ready_in <= 1'b0;
         repeat (3) @(posedge ref_clk);
         wake_event <= 1'b1;
         @(posedge ref_clk);
         wake_event <= 1'b0;
         repeat (3) @(posedge ref_clk);
         chk(32'({sleep_mode, idle_mode}), 32'h0);
         chk(32'(clock_mux_select), (i == 1) ? 32'h0 : 32'h2);
         source_ready_in <= 1'b1;
         repeat (6) @(posedge ref_clk);
         chk(32'(clock_mux_select), 32'h2);
      end
      $display("t_wait done");
   endtask
   task automatic t_fail;
      apb(1'b1, 12'h034, 32'h1);
      @(posedge ref_clk);
      clock_loss_in <= 1'b1;
      for (i = 0; i < 10 && nmi_out !== 1'b1; i++) @(posedge ref_clk);
      chk(32'(nmi_out), 32'h1);
      clock_loss_in <= 1'b0;
      @(negedge ref_clk);
      chk(32'({clock_mux_select, irq}), 32'h1);
      rd(12'h000, 32'h0000_7008, 32'h0000_0008);
      $display("t_fail done");
   endtask
   task automatic t_lock;
      wu(12'h000, 32'h07A0_0586);
      rd(12'h000, 32'h0000_0008, 32'h0);
      wu(12'h000, 32'h07A0_0187);
      rd(12'h000, 32'h0000_0781, 32'h0000_0580);
      chk(32'(switch_target), 32'h5);
      $display("t_lock done");
   endtask
   // Verdict and end of run
   task automatic end_of_test;
      $display("checks %0d errors %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (8) @(posedge ref_clk);
      rst <= 1'b0;
      t_reset;
      t_fields;
      t_switch;
      t_wait;
      t_fail;
      t_lock;
      end_of_test;
   end
   // Watchdog
   initial begin
      repeat (20000) @(posedge ref_clk);
      err_total++;
      end_of_test;
   end
endmodule
